// *** logic/iox_expander.sv ***
// serial-bus slave with sixteen general purpose pins in two byte ports
// assumes i_scl also clocks the link side; pins, straps and bus lines are
// asynchronous and are synchronised before the engine reads them
//
// Notes on behaviour
// - read transfers return bytes without any limit
// - restart leaves command at register being read
// - further read bytes alternate within register pair
// - input register captured at acknowledge clock rise
// - stop ends transfer anytime; output latches kept
// - address is fixed high bits plus straps
// - address low bit: one reads, zero writes
// - first written byte becomes command byte
// - command low three bits select eight registers
// - commanded register steps within pair until next command
// - input registers report pins, ignore writes
// - output latches drive outputs, read back latch
// - invert bit set flips reported input level
// - direction bit set makes pin high-impedance input
// - input pin change raises alert; return/read clears
// - alert cleared per port; outputs never alert
`timescale 1ns/1ps
`include "iox_defines.svh"
module iox_expander (
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe,
   input wire logic i_addr_strap_bit0,
   input wire logic i_addr_strap_bit1,
   input wire logic i_addr_strap_bit2,
   input wire logic [15:0] i_port_pins,
   output logic [15:0] o_port_pins,
   output logic [15:0] o_port_oe,
   output logic o_alert_oe
);

   // ==========================================
   // link side on the bus clock
   // data only, rewritten at every rising bus clock before the engine
   // looks at it, so it needs no reset
   logic link_bit;
   logic [15:0] link_pins;

   always_ff @(posedge i_scl) begin
      link_bit <= i_sda;
      link_pins <= i_port_pins;
   end

   // ==========================================
   // synchronisers and bus events
   iox_pkg::iox_pins_t raw;
   iox_pkg::iox_pins_t syn;
   logic scl_q;
   logic sda_q;
   logic [1:0] init_cnt;

   // the synchroniser leaves reset at zero while the idle bus is high, so
   // the first edges after reset are false ones and are masked here
   wire init_run = (init_cnt != `IOX_INIT_DONE);

   assign raw.strap = {i_addr_strap_bit2, i_addr_strap_bit1, i_addr_strap_bit0};
   assign raw.scl = i_scl;
   assign raw.sda = i_sda;
   assign raw.port = i_port_pins;

   iox_sync2 #(.WIDTH($bits(iox_pkg::iox_pins_t))) u_sync (
      .i_clk(i_sys_clk),
      .i_nrst(i_nrst),
      .i_d(raw),
      .o_q(syn)
   );

   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         scl_q <= 1'b0;
         sda_q <= 1'b0;
      end else begin
         scl_q <= syn.scl;
         sda_q <= syn.sda;
      end
   end

   // the link bit is stable long before the synchronised rise is seen
   wire scl_rise = syn.scl & ~scl_q & ~init_run;
   wire scl_fall = ~syn.scl & scl_q & ~init_run;
   wire start_ev = scl_q & syn.scl & sda_q & ~syn.sda & ~init_run;
   wire stop_ev = scl_q & syn.scl & ~sda_q & syn.sda & ~init_run;

   // ==========================================
   // engine state
   iox_pkg::iox_state_t st;
   iox_pkg::iox_state_t next_st;
   logic [3:0] cnt;
   logic [7:0] shreg;
   logic [7:0] txsh;
   logic [2:0] ptr;
   logic rw;
   logic first;
   logic nack;
   logic next_sda_oe;

   wire in_addr = (st == iox_pkg::IOX_ST_ADDR);
   wire in_addr_ack = (st == iox_pkg::IOX_ST_ADDR_ACK);
   wire in_rx = (st == iox_pkg::IOX_ST_RX);
   wire in_rx_ack = (st == iox_pkg::IOX_ST_RX_ACK);
   wire in_tx = (st == iox_pkg::IOX_ST_TX);
   wire in_tx_ack = (st == iox_pkg::IOX_ST_TX_ACK);
   wire byte_done = (cnt == `IOX_BYTE_BITS);
   wire bus_ev = start_ev | stop_ev;

   wire addr_hit = (shreg[7:1] == {`IOX_ADDR_HI, syn.strap});
   wire cmd_stb = scl_fall & in_rx & byte_done & first & ~bus_ev;
   wire wr_stb = scl_fall & in_rx & byte_done & ~first & ~bus_ev;
   wire ack_cap = scl_rise & (in_addr_ack | in_rx_ack | in_tx_ack);
   wire go_on = scl_fall & in_tx_ack & ~nack & ~bus_ev;
   wire tx_load = (scl_fall & in_addr_ack & rw & ~bus_ev) | go_on;

   // next byte to send: the other register of the pair after an ack
   wire [2:0] rd_ptr = in_tx_ack ? {ptr[2:1], ~ptr[0]} : ptr;
   wire rd_clr = (scl_rise & in_addr_ack & rw) | (scl_rise & in_tx_ack & ~link_bit);
   wire rd_input = rd_clr & (rd_ptr[2:1] == `IOX_PAIR_INPUT);

   // ==========================================
   // per-port registers and change alert
   logic [15:0] in_reg;
   logic [15:0] out_lat;
   logic [15:0] inv_all;
   logic [15:0] dir_all;
   logic [1:0] alert_v;

   genvar p;
   generate
      for (p = 0; p < 2; p++) begin : g_port
         logic [7:0] out_q;
         logic [7:0] inv_q;
         logic [7:0] dir_q;
         logic [7:0] in_q;
         logic [7:0] snap_q;
         wire [7:0] live = syn.port[p*8 +: 8];
         wire wr_me = wr_stb & (ptr[0] == 1'(p));
         wire rd_me = rd_input & (rd_ptr[0] == 1'(p));

         always_ff @(posedge i_sys_clk) begin
            if (!i_nrst) begin
               out_q <= `IOX_OUT_RST;
               inv_q <= `IOX_INV_RST;
               dir_q <= `IOX_DIR_RST;
               in_q <= 8'h00;
               snap_q <= 8'h00;
            end else begin
               if (wr_me && ptr[2:1] == `IOX_PAIR_OUTPUT) begin
                  out_q <= shreg;
               end
               if (wr_me && ptr[2:1] == `IOX_PAIR_INVERT) begin
                  inv_q <= shreg;
               end
               if (wr_me && ptr[2:1] == `IOX_PAIR_DIR) begin
                  dir_q <= shreg;
               end
               if (ack_cap) begin
                  in_q <= link_pins[p*8 +: 8] ^ inv_q;
               end
               // reading the port re-arms only this port's alert
               if (init_run || rd_me) begin
                  snap_q <= live;
               end
            end
         end

         // pins driven as outputs are masked out of the alert
         assign alert_v[p] = |((live ^ snap_q) & dir_q);
         assign in_reg[p*8 +: 8] = in_q;
         assign out_lat[p*8 +: 8] = out_q;
         assign inv_all[p*8 +: 8] = inv_q;
         assign dir_all[p*8 +: 8] = dir_q;
      end
   endgenerate

   // ==========================================
   // read data selection
   wire [15:0] rd_pair = (rd_ptr[2:1] == `IOX_PAIR_INPUT) ? in_reg :
                         (rd_ptr[2:1] == `IOX_PAIR_OUTPUT) ? out_lat :
                         (rd_ptr[2:1] == `IOX_PAIR_INVERT) ? inv_all : dir_all;
   wire [7:0] rd_byte = rd_ptr[0] ? rd_pair[15:8] : rd_pair[7:0];

   // ==========================================
   // next state and data line drive
   always_comb begin
      next_st = st;
      next_sda_oe = o_sda_oe;
      if (start_ev) begin
         next_st = iox_pkg::IOX_ST_ADDR;
         next_sda_oe = 1'b0;
      end else if (stop_ev) begin
         next_st = iox_pkg::IOX_ST_IDLE;
         next_sda_oe = 1'b0;
      end else if (scl_fall) begin
         case (st)
            iox_pkg::IOX_ST_ADDR: begin
               if (byte_done) begin
                  next_st = addr_hit ? iox_pkg::IOX_ST_ADDR_ACK : iox_pkg::IOX_ST_IDLE;
                  next_sda_oe = addr_hit;
               end
            end
            iox_pkg::IOX_ST_ADDR_ACK: begin
               next_st = rw ? iox_pkg::IOX_ST_TX : iox_pkg::IOX_ST_RX;
               next_sda_oe = rw & ~rd_byte[7];
            end
            iox_pkg::IOX_ST_RX: begin
               if (byte_done) begin
                  next_st = iox_pkg::IOX_ST_RX_ACK;
                  next_sda_oe = 1'b1;
               end
            end
            iox_pkg::IOX_ST_RX_ACK: begin
               next_st = iox_pkg::IOX_ST_RX;
               next_sda_oe = 1'b0;
            end
            iox_pkg::IOX_ST_TX: begin
               if (byte_done) begin
                  next_st = iox_pkg::IOX_ST_TX_ACK;
                  next_sda_oe = 1'b0;
               end else begin
                  next_sda_oe = ~txsh[6];
               end
            end
            iox_pkg::IOX_ST_TX_ACK: begin
               // a refused byte ends the read and frees the line
               next_st = nack ? iox_pkg::IOX_ST_IDLE : iox_pkg::IOX_ST_TX;
               next_sda_oe = ~nack & ~rd_byte[7];
            end
            default: begin
               next_st = st;
               next_sda_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         st <= iox_pkg::IOX_ST_IDLE;
         o_sda_oe <= 1'b0;
         o_sda <= 1'b0;
         init_cnt <= 2'h0;
      end else begin
         st <= next_st;
         o_sda_oe <= next_sda_oe;
         o_sda <= 1'b0;
         init_cnt <= init_run ? init_cnt + 2'h1 : init_cnt;
      end
   end

   // ==========================================
   // bit counter and shift registers
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         cnt <= 4'h0;
      end else if (start_ev) begin
         cnt <= 4'h0;
      end else if (scl_rise && (in_addr || in_rx || in_tx)) begin
         cnt <= cnt + 4'h1;
      end else if (scl_fall && (in_addr_ack || in_rx_ack || in_tx_ack)) begin
         cnt <= 4'h0;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         shreg <= 8'h00;
         txsh <= 8'h00;
      end else begin
         if (scl_rise && (in_addr || in_rx)) begin
            shreg <= {shreg[6:0], link_bit};
         end
         if (tx_load) begin
            txsh <= rd_byte;
         end else if (scl_fall && in_tx && !byte_done) begin
            txsh <= {txsh[6:0], 1'b0};
         end
      end
   end

   // ==========================================
   // transfer flags and command pointer
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         rw <= 1'b0;
         first <= 1'b0;
         nack <= 1'b1;
      end else begin
         if (scl_fall && in_addr && byte_done) begin
            rw <= shreg[0];
         end
         if (scl_fall && in_addr_ack) begin
            first <= 1'b1;
         end else if (cmd_stb) begin
            first <= 1'b0;
         end
         if (scl_rise && in_tx_ack) begin
            nack <= link_bit;
         end
      end
   end

   // the pointer is the stored command, so a restart simply keeps
   // whatever register the transfer had reached
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         ptr <= `IOX_CMD_RST;
      end else if (cmd_stb) begin
         ptr <= shreg[2:0];
      end else if (wr_stb) begin
         ptr <= {ptr[2:1], ~ptr[0]};
      end else if (go_on) begin
         ptr <= rd_ptr;
      end
   end

   // ==========================================
   // pin outputs
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         o_port_pins <= {`IOX_OUT_RST, `IOX_OUT_RST};
         o_port_oe <= 16'h0000;
         o_alert_oe <= 1'b0;
      end else begin
         o_port_pins <= out_lat;
         o_port_oe <= ~dir_all;
         o_alert_oe <= |alert_v;
      end
   end

   // ==========================================
   // assertions
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_nrst);

   property p_addr_match;
      in_addr_ack |-> shreg[7:1] == {`IOX_ADDR_HI, syn.strap};
   endproperty
   a_addr_match: assert property (p_addr_match) else $error("ack given to wrong address");

   property p_foreign;
      (scl_fall && in_addr && byte_done && !addr_hit && !bus_ev) |=> st == iox_pkg::IOX_ST_IDLE && !o_sda_oe;
   endproperty
   a_foreign: assert property (p_foreign) else $error("foreign address not ignored");

   property p_direction;
      (scl_fall && in_addr_ack && !bus_ev) |=> (in_tx == $past(rw)) && (in_rx == !$past(rw));
   endproperty
   a_direction: assert property (p_direction) else $error("direction bit misread");

   property p_command;
      cmd_stb |=> ptr == $past(shreg[2:0]) ##1 !first;
   endproperty
   a_command: assert property (p_command) else $error("command byte not stored");

   property p_input_ro;
      (wr_stb && ptr[2:1] == `IOX_PAIR_INPUT) |=> $stable(in_reg);
   endproperty
   a_input_ro: assert property (p_input_ro) else $error("input register written");

   property p_pair_step;
      go_on |=> ptr == {$past(ptr[2:1]), ~$past(ptr[0])} && in_tx;
   endproperty
   a_pair_step: assert property (p_pair_step) else $error("read did not alternate in pair");

   property p_keep_cmd;
      !(cmd_stb || wr_stb || go_on) |=> $stable(ptr);
   endproperty
   a_keep_cmd: assert property (p_keep_cmd) else $error("command pointer drifted");

   property p_capture;
      ack_cap |=> in_reg == ($past(link_pins) ^ $past(inv_all));
   endproperty
   a_capture: assert property (p_capture) else $error("input capture wrong");

   property p_all_inputs;
      (dir_all == 16'hFFFF) [*2] |-> o_port_oe == 16'h0000;
   endproperty
   a_all_inputs: assert property (p_all_inputs) else $error("input pin driven");

   property p_outputs_quiet;
      (dir_all == 16'h0000) [*2] |-> !o_alert_oe;
   endproperty
   a_outputs_quiet: assert property (p_outputs_quiet) else $error("output pin raised alert");

   property p_stop;
      stop_ev |=> st == iox_pkg::IOX_ST_IDLE && !o_sda_oe ##1 $stable(o_port_pins);
   endproperty
   a_stop: assert property (p_stop) else $error("stop not honoured");

   c_two_byte_read: cover property (go_on ##[1:1000] (scl_fall && in_tx_ack && nack));
   c_out_write: cover property (wr_stb && ptr[2:1] == `IOX_PAIR_OUTPUT);
   c_restart: cover property (in_tx ##[1:1000] start_ev);
   c_alert: cover property (!o_alert_oe ##1 o_alert_oe);

endmodule

// *** logic/iox_defines.svh ***
// constants of the sixteen-bit port expander: address, register codes,
// reset values and small counts; included by the design files
`ifndef IOX_DEFINES_SVH
`define IOX_DEFINES_SVH

// fixed upper four bits of the seven-bit slave address
`define IOX_ADDR_HI 4'h4

// register select codes held in the command byte
`define IOX_REG_INPUT0 3'h0
`define IOX_REG_INPUT1 3'h1
`define IOX_REG_OUTPUT0 3'h2
`define IOX_REG_OUTPUT1 3'h3
`define IOX_REG_INVERT0 3'h4
`define IOX_REG_INVERT1 3'h5
`define IOX_REG_DIR0 3'h6
`define IOX_REG_DIR1 3'h7

// register pair codes (upper two select bits)
`define IOX_PAIR_INPUT 2'h0
`define IOX_PAIR_OUTPUT 2'h1
`define IOX_PAIR_INVERT 2'h2
`define IOX_PAIR_DIR 2'h3

// reset values
`define IOX_OUT_RST 8'hFF
`define IOX_INV_RST 8'h00
`define IOX_DIR_RST 8'hFF
`define IOX_CMD_RST 3'h0

// bits of a byte before the acknowledge slot
`define IOX_BYTE_BITS 4'h8

// system cycles after reset release before the synchronised pins are trusted
`define IOX_INIT_DONE 2'h3

`endif

// *** logic/iox_pkg.sv ***
// types shared by the port expander design files
// assumes the constants header is compiled alongside
package iox_pkg;

   // serial engine states, gray coded along the usual path
   typedef enum logic [2:0] {
      IOX_ST_IDLE = 3'h0,
      IOX_ST_ADDR = 3'h1,
      IOX_ST_ADDR_ACK = 3'h3,
      IOX_ST_RX = 3'h2,
      IOX_ST_RX_ACK = 3'h6,
      IOX_ST_TX = 3'h7,
      IOX_ST_TX_ACK = 3'h5
   } iox_state_t;

   // pin levels that cross into the system clock together
   typedef struct packed {
      logic [2:0] strap;
      logic scl;
      logic sda;
      logic [15:0] port;
   } iox_pins_t;

endpackage

// *** logic/iox_sync2.sv ***
// two flip-flop synchroniser for a group of asynchronous levels
// assumes each bit is a slow level; no relation between bits is kept
`timescale 1ns/1ps
module iox_sync2 #(
   parameter int WIDTH = 21
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic [WIDTH-1:0] i_d,
   output logic [WIDTH-1:0] o_q
);

   // ==========================================
   // synchroniser stages
   logic [WIDTH-1:0] meta;

   // first stage is read only by the second
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         meta <= '0;
         o_q <= '0;
      end else begin
         meta <= i_d;
         o_q <= meta;
      end
   end

endmodule

// *** verification/iox_bus_master.sv ***
// bus master model for the port expander: start, stop, byte slots
// assumes the bench resolves the open-drain data wire with a pull-up
`timescale 1ns/1ps
module iox_bus_master (
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_pull,
   output logic o_res_valid,
   output logic [8:0] o_res
);
   // ==========
   // timing: a quarter of the 80 ns link period
   localparam time QTR = 20ns;
   initial begin
      o_scl = 1'b1;
      o_sda_pull = 1'b0;
      o_res_valid = 1'b0;
      o_res = 9'h000;
   end
   task automatic post(input logic [8:0] v);
      o_res = v;
      o_res_valid = 1'b1;
      #1 o_res_valid = 1'b0;
   endtask
   // first quarter lets the slave let go of an ack before data rises
   task automatic start();
      #1.3;
      #QTR o_sda_pull = 1'b0;
      #QTR o_scl = 1'b1;
      #QTR o_sda_pull = 1'b1;
      #QTR o_scl = 1'b0;
   endtask
   // may cut a byte short; the clock then stands high
   task automatic stop();
      #QTR o_sda_pull = 1'b1;
      #QTR o_scl = 1'b1;
      #QTR o_sda_pull = 1'b0;
      #QTR;
   endtask
   task automatic slot(input logic lvl, output logic seen);
      #QTR o_sda_pull = ~lvl;
      #QTR o_scl = 1'b1;
      #QTR seen = i_sda;
      #QTR o_scl = 1'b0;
   endtask
   task automatic wbyte(input logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) slot(b[i], s);
      slot(1'b1, s);
      post({~s, b});
   endtask
   // all bytes acknowledged except the last one
   task automatic rbyte(input logic last);
      logic [7:0] d;
      logic s;
      for (int i = 7; i >= 0; i--) begin
         slot(1'b1, s);
         d[i] = s;
      end
      slot(last, s);
      post({1'b0, d});
   endtask
endmodule

// *** verification/iox_expander_bench.sv ***
// self-checking bench of the port expander with a bus master model
// assumes the design files and the constants header compile first
`timescale 1ns/1ps
`include "iox_defines.svh"
module iox_expander_bench;
   logic clk, nrst, scl, pull, res_valid, sda_oe, sda_out, alert, sda_wire;
   logic [2:0] strap;
   logic [6:0] dev;
   logic [8:0] res;
   logic [15:0] ext, pins_out, pins_oe, pins;
   logic [7:0] rv [8];
   logic [8:0] exp_q [$];
   int seed, fail_count, comparisons;
   assign dev = {`IOX_ADDR_HI, strap};
   assign sda_wire = ~(pull | (sda_oe & ~sda_out));
   // driven pins show the latch, the rest what the outside applies
   assign pins = (pins_oe & pins_out) | (~pins_oe & ext);
   always #2.5 clk = ~clk;
   iox_expander dut (
      .i_sys_clk(clk),
      .i_nrst(nrst),
      .i_scl(scl),
      .i_sda(sda_wire),
      .o_sda(sda_out),
      .o_sda_oe(sda_oe),
      .i_addr_strap_bit0(strap[0]),
      .i_addr_strap_bit1(strap[1]),
      .i_addr_strap_bit2(strap[2]),
      .i_port_pins(pins),
      .o_port_pins(pins_out),
      .o_port_oe(pins_oe),
      .o_alert_oe(alert)
   );
   iox_bus_master m (
      .i_sda(sda_wire),
      .o_scl(scl),
      .o_sda_pull(pull),
      .o_res_valid(res_valid),
      .o_res(res)
   );
   // ==========
   // checking
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      comparisons++;
      if (seen !== want) begin
         fail_count++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   always @(posedge res_valid) begin
      if (exp_q.size() == 0) check({23'h0, res}, 32'hXXXXXXXX);
      else check({23'h0, res}, {23'h0, exp_q.pop_front()});
   end
   // input registers report pin level through the invert mask
   function automatic logic [7:0] exp_reg(input logic [2:0] c);
      logic [15:0] lvl;
      lvl = ({rv[7], rv[6]} & ext) | (~{rv[7], rv[6]} & {rv[3], rv[2]});
      if (c == 3'h0) return lvl[7:0] ^ rv[4];
      if (c == 3'h1) return lvl[15:8] ^ rv[5];
      return rv[c];
   endfunction
   function automatic logic [7:0] rnd();
      return 8'($random(seed));
   endfunction
   // ==========
   // stimulus
   task automatic reset_dut(input logic [2:0] s);
      @(negedge clk);
      nrst = 1'b0;
      strap = s;
      repeat (16) @(negedge clk);
      check({pins_oe, pins_out}, {16'h0000, `IOX_OUT_RST, `IOX_OUT_RST});
      check({30'h0, sda_oe, alert}, 32'h0);
      nrst = 1'b1;
      rv = '{8'h00, 8'h00, `IOX_OUT_RST, `IOX_OUT_RST, `IOX_INV_RST, `IOX_INV_RST, `IOX_DIR_RST, `IOX_DIR_RST};
      repeat (12) @(negedge clk);
   endtask
   task automatic probe(input logic [6:0] a, input logic ack);
      exp_q.push_back({ack, a, 1'b0});
      m.start();
      m.wbyte({a, 1'b0});
      m.stop();
   endtask
   // abort cuts the next data byte after three bits
   task automatic wr(input logic [2:0] c, input logic [7:0] d0, input logic [7:0] d1, input int n, input logic abort);
      logic [7:0] d;
      logic junk;
      exp_q.push_back({1'b1, dev, 1'b0});
      m.start();
      m.wbyte({dev, 1'b0});
      exp_q.push_back({1'b1, 5'h00, c});
      m.wbyte({5'h00, c});
      for (int i = 0; i < n; i++) begin
         d = i[0] ? d1 : d0;
         exp_q.push_back({1'b1, d});
         m.wbyte(d);
         if (c[2:1] != 2'h0) rv[{c[2:1], c[0] ^ i[0]}] = d;
      end
      if (abort) repeat (3) m.slot(1'b0, junk);
      m.stop();
   endtask
   // without a command byte the restart reads the stored register
   task automatic rd(input logic [2:0] c, input logic setcmd, input int n);
      exp_q.push_back({1'b1, dev, 1'b0});
      m.start();
      m.wbyte({dev, 1'b0});
      if (setcmd) exp_q.push_back({1'b1, 5'h00, c});
      if (setcmd) m.wbyte({5'h00, c});
      exp_q.push_back({1'b1, dev, 1'b1});
      m.start();
      m.wbyte({dev, 1'b1});
      for (int i = 0; i < n; i++) begin
         exp_q.push_back({1'b0, exp_reg({c[2:1], c[0] ^ i[0]})});
         m.rbyte(i == n - 1);
      end
      m.stop();
   endtask
   task automatic wait_alert(input logic v);
      int k;
      k = 0;
      while (alert !== v && k < 40) begin
         @(negedge clk);
         k++;
      end
      check({31'h0, alert}, {31'h0, v});
      if (k == 40) test_done();
   endtask
   initial begin
      clk = 1'b0;
      nrst = 1'b0;
      strap = 3'h0;
      ext = 16'h0000;
      seed = 72;
      fail_count = 0;
      comparisons = 0;
      for (int s = 0; s < 8; s++) begin
         reset_dut(s[2:0]);
         probe(dev, 1'b1);
         probe({`IOX_ADDR_HI, strap ^ 3'h1}, 1'b0);
      end
      $display("address test done");
      check({31'h0, alert}, 32'h0);
      @(negedge clk) ext = 16'h0100;
      wait_alert(1'b1);
      rd(3'h0, 1'b1, 1);
      check({31'h0, alert}, 32'h1);
      rd(3'h1, 1'b1, 1);
      check({31'h0, alert}, 32'h0);
      @(negedge clk) ext = 16'h0101;
      wait_alert(1'b1);
      @(negedge clk) ext = 16'h0100;
      wait_alert(1'b0);
      wr(3'h6, 8'h00, 8'h00, 2, 1'b0);
      wr(3'h2, rnd(), rnd(), 2, 1'b0);
      @(negedge clk) ext = ~ext;
      repeat (20) @(negedge clk);
      check({31'h0, alert}, 32'h0);
      $display("alert test done");
      wr(3'h4, rnd(), rnd(), 2, 1'b0);
      wr(3'h6, rnd(), rnd(), 2, 1'b0);
      @(negedge clk) ext = 16'($random(seed));
      repeat (4) @(negedge clk);
      check({pins_oe, pins_out}, {~rv[7], ~rv[6], rv[3], rv[2]});
      for (int c = 0; c < 8; c++) rd(c[2:0], 1'b1, 2);
      wr(3'h0, rnd(), rnd(), 2, 1'b0);
      rd(3'h0, 1'b1, 3);
      $display("register test done");
      rd(3'h1, 1'b1, 2);
      rd(3'h0, 1'b0, 1);
      rd(3'h0, 1'b0, 2);
      $display("restart test done");
      wr(3'h2, rnd(), rnd(), 1, 1'b1);
      check({16'h0, pins_out}, {16'h0, rv[3], rv[2]});
      rd(3'h2, 1'b1, 2);
      $display("stop test done");
      check(exp_q.size(), 0);
      test_done();
   end
endmodule
